// [hps_dev_end.sv]
// host port slave: strobe handshake, word assembly and dma bus requests
// Function
// [R01] slave giving host memory, boot, i/o access
// [R02] shared multiplexed bus, 8 or 16 bit
// [R03] internal access steals one core cycle
// [R04] external access steals no core cycle
// [R05] dma auto-increments the target address
// [R06] auto-detect latch or address-cycle addressing
// [R07] polarity captured at reset, read-only bit
// [R08] read completes once data valid, no write
// [R09] write completes once buffer free, no write
// [R10] bits 7:6 select ack, bit7 resets 0
// [R11] bit6 set when strap equals ack
// [R12] ack mode: assert when ready, drop after strobe
// [R13] host holds strobe until ack seen
// [R14] ready mode: drop ready to insert waits
// [R15] host holds strobe while ready low
// [R16] address cycles always acknowledged
// [R17] memory select and i/o select, active low
// [R18] host programs width and page first
// [R19] port decodes memory selects from address
// [R20] merge up to three accesses per word; the code merges four when cfg bits 3:2 are 3
// [R21] early ack for bytes not needing memory
// [R22] dma bus priority ten
// [R23] low polarity inverts ack and ready levels
`timescale 1ns/10ps
`default_nettype none
module hps_dev_end (
    input wire logic REF_CLK,
    input wire logic RST_N,
    hps_link_if.dev LINK,
    output logic DMA_REQ,
    output logic DMA_WR,
    output logic [hps_pkg::HPS_AW-1:0] DMA_ADDR,
    output logic [hps_pkg::HPS_WW-1:0] DMA_WDATA,
    input wire logic [hps_pkg::HPS_WW-1:0] DMA_RDATA,
    input wire logic DMA_DONE,
    output logic [3:0] DMA_PRIORITY,
    output logic SEL_INT_MEM,
    output logic SEL_EXT_MEM,
    output logic SEL_BOOT,
    output logic SEL_IO,
    output logic CORE_STEAL
);
    import hps_pkg::*;

    // place a beat into the assembly word
    function automatic logic [23:0] lane_put(input logic [23:0] a, input logic [1:0] k,
                                             input logic [15:0] d, input logic w);
        logic [23:0] r;
        r = a;
        if (w) begin
            if (k == 2'h0) r[15:0] = d;
            else r[23:16] = d[7:0];
        end else begin
            unique case (k)
                2'h0: r[7:0] = d[7:0];
                2'h1: r[15:8] = d[7:0];
                default: r[23:16] = d[7:0];
            endcase
        end
        return r;
    endfunction

    // take a beat out of the assembly word
    function automatic logic [15:0] lane_get(input logic [23:0] a, input logic [1:0] k,
                                             input logic w);
        logic [15:0] r;
        r = 16'h0000;
        if (w) begin
            if (k == 2'h0) r = a[15:0];
            else r = {8'h00, a[23:16]};
        end else begin
            unique case (k)
                2'h0: r = {8'h00, a[7:0]};
                2'h1: r = {8'h00, a[15:8]};
                default: r = {8'h00, a[23:16]};
            endcase
        end
        return r;
    endfunction

    // target space from select and page: {io, boot, ext, int}
    function automatic logic [3:0] space(input logic io, input logic [7:0] pg);
        logic [3:0] r;
        r = 4'h0;
        if (io) r = 4'h8;
        else if (pg == HPS_PAGE_BOOT) r = 4'h4;
        else if (pg == HPS_PAGE_INT) r = 4'h1;
        else r = 4'h2;
        return r;
    endfunction

    hps_dma_e st_r, st_nxt;
    logic [15:0] cfg_r, cfg_nxt;
    logic [7:0] page_r, page_nxt;
    logic [15:0] addr_r, addr_nxt;
    logic [1:0] beat_r, beat_nxt;
    logic [1:0] lane_r, lane_nxt;
    logic [23:0] asm_r, asm_nxt;
    logic done_r, done_nxt;
    logic regrd_r, regrd_nxt;
    logic wrop_r, wrop_nxt;
    logic io_r, io_nxt;
    logic stb_q_r;
    logic steal_r, steal_nxt;
    logic req_r, req_nxt;
    logic [23:0] daddr_r, daddr_nxt;
    logic [23:0] wdata_r, wdata_nxt;
    logic [3:0] sel_r, sel_nxt;
    logic ack_r, ack_nxt;
    logic ack_oe_n_r, ack_oe_n_nxt;
    logic [15:0] ad_r, ad_nxt;
    logic ad_oe_n_r, ad_oe_n_nxt;
    logic cs, rd, wr, stb, lead, ale, is_reg, act, wide;
    logic [1:0] last;

    // strobe decode; either chip select opens the port
    assign cs = !LINK.host_memory_select_n || !LINK.host_io_space_select_n; // [R17]
    assign rd = cs && !LINK.host_read_strobe_n;
    assign wr = cs && !LINK.host_write_strobe_n;
    assign stb = rd || wr;
    assign lead = stb && !stb_q_r;
    assign ale = LINK.host_address_latch_input;
    assign is_reg = !LINK.host_io_space_select_n
        && (addr_r == HPS_REG_CFG || addr_r == HPS_REG_PAGE);
    assign wide = cfg_r[HPS_CFG_WIDE];
    assign last = cfg_r[HPS_CFG_BEAT+1:HPS_CFG_BEAT];

    // access sequencing, assembly and dma requests
    always_comb begin
        st_nxt = st_r;
        cfg_nxt = cfg_r;
        page_nxt = page_r;
        addr_nxt = addr_r;
        beat_nxt = beat_r;
        lane_nxt = lane_r;
        asm_nxt = asm_r;
        done_nxt = done_r;
        regrd_nxt = regrd_r;
        wrop_nxt = wrop_r;
        io_nxt = io_r;
        steal_nxt = 1'b0;
        if (!stb) done_nxt = 1'b0; // completion ends with the strobe [R12]
        if (ale && !stb) begin
            // bare latch pulse: latch-strobe addressing [R06]
            addr_nxt = LINK.ad;
            beat_nxt = 2'h0;
            cfg_nxt[HPS_CFG_ACC] = 1'b0;
        end else if (lead && ale && wr) begin
            // write strobe with latch high: address cycle, acked at once [R06] [R16]
            addr_nxt = LINK.ad;
            beat_nxt = 2'h0;
            cfg_nxt[HPS_CFG_ACC] = 1'b1;
            done_nxt = 1'b1;
        end else if (lead && st_r == HPS_D_IDLE) begin
            lane_nxt = beat_r;
            regrd_nxt = 1'b0;
            io_nxt = !LINK.host_io_space_select_n;
            if (is_reg) begin
                done_nxt = 1'b1;
                if (wr && addr_r == HPS_REG_CFG) begin
                    cfg_nxt = (cfg_r & ~HPS_CFG_WMASK) | (LINK.ad & HPS_CFG_WMASK); // [R10]
                end else if (wr) begin
                    page_nxt = LINK.ad[7:0];
                end else begin
                    regrd_nxt = 1'b1;
                end
            end else begin
                beat_nxt = (beat_r == last) ? 2'h0 : 2'(beat_r + 2'h1); // [R20]
                if (wr) begin
                    asm_nxt = lane_put(asm_r, beat_r, LINK.ad, wide); // [R02]
                    if (beat_r == last) begin
                        st_nxt = HPS_D_BUSY; // posted word, ack after memory [R09] [R21]
                        wrop_nxt = 1'b1;
                    end else begin
                        done_nxt = 1'b1; // [R21]
                    end
                end else if (beat_r == 2'h0) begin
                    st_nxt = HPS_D_BUSY; // prefetch the word [R08] [R20]
                    wrop_nxt = 1'b0;
                end else begin
                    done_nxt = 1'b1; // [R21]
                end
            end
        end
        if (st_r == HPS_D_BUSY && DMA_DONE) begin
            st_nxt = HPS_D_IDLE;
            done_nxt = 1'b1;
            addr_nxt = addr_r + 16'h0001; // [R05]
            if (!wrop_r) asm_nxt = DMA_RDATA;
            steal_nxt = sel_r[0]; // internal only [R03] [R04]
        end
        if (!RST_N) begin
            // strap capture; bit7 clears [R07] [R10] [R11]
            cfg_nxt = 16'h0000;
            cfg_nxt[HPS_CFG_POL] = LINK.acknowledge_polarity_strap;
            cfg_nxt[HPS_CFG_READY] = LINK.acknowledge_polarity_strap == LINK.host_acknowledge;
            cfg_nxt[HPS_CFG_M7] = 1'b0;
        end
        req_nxt = st_nxt == HPS_D_BUSY;
        daddr_nxt = {page_nxt, addr_nxt};
        wdata_nxt = asm_nxt;
        sel_nxt = space(io_nxt, page_nxt); // [R01] [R19]
    end

    // acknowledge, ready and read data pins
    always_comb begin
        if (cfg_r[HPS_CFG_READY]) act = !(stb && !done_r); // waits [R14]
        else act = stb && done_r; // [R12]
        ack_nxt = cfg_r[HPS_CFG_POL] ? act : !act; // [R23]
        ack_oe_n_nxt = !cs;
        ad_nxt = regrd_r ? (addr_r == HPS_REG_CFG ? cfg_r : {8'h00, page_r})
            : lane_get(asm_r, lane_r, wide);
        ad_oe_n_nxt = !(rd && done_r);
    end

    // state registers
    always_ff @(posedge REF_CLK) begin
        cfg_r <= cfg_nxt;
        if (!RST_N) begin
            st_r <= HPS_D_IDLE;
            page_r <= HPS_PAGE_RST;
            addr_r <= 16'h0000;
            beat_r <= 2'h0;
            lane_r <= 2'h0;
            asm_r <= 24'h00_0000;
            done_r <= 1'b0;
            regrd_r <= 1'b0;
            wrop_r <= 1'b0;
            io_r <= 1'b0;
            stb_q_r <= 1'b0;
            steal_r <= 1'b0;
            req_r <= 1'b0;
            daddr_r <= 24'h00_0000;
            wdata_r <= 24'h00_0000;
            sel_r <= 4'h0;
            ack_r <= 1'b0;
            ack_oe_n_r <= 1'b1;
            ad_r <= 16'h0000;
            ad_oe_n_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            page_r <= page_nxt;
            addr_r <= addr_nxt;
            beat_r <= beat_nxt;
            lane_r <= lane_nxt;
            asm_r <= asm_nxt;
            done_r <= done_nxt;
            regrd_r <= regrd_nxt;
            wrop_r <= wrop_nxt;
            io_r <= io_nxt;
            stb_q_r <= stb;
            steal_r <= steal_nxt;
            req_r <= req_nxt;
            daddr_r <= daddr_nxt;
            wdata_r <= wdata_nxt;
            sel_r <= sel_nxt;
            ack_r <= ack_nxt;
            ack_oe_n_r <= ack_oe_n_nxt;
            ad_r <= ad_nxt;
            ad_oe_n_r <= ad_oe_n_nxt;
        end
    end

    // outputs straight from registers, except the constant dma priority
    assign LINK.dev_ack = ack_r;
    assign LINK.dev_ack_oe_n = ack_oe_n_r;
    assign LINK.dev_ad = ad_r;
    assign LINK.dev_ad_oe_n = ad_oe_n_r;
    assign DMA_REQ = req_r;
    assign DMA_WR = wrop_r;
    assign DMA_ADDR = daddr_r;
    assign DMA_WDATA = wdata_r;
    assign DMA_PRIORITY = HPS_DMA_PRIO; // fixed arbitration level [R22]
    assign SEL_INT_MEM = sel_r[0];
    assign SEL_EXT_MEM = sel_r[1];
    assign SEL_BOOT = sel_r[2];
    assign SEL_IO = sel_r[3];
    assign CORE_STEAL = steal_r;
endmodule
`default_nettype wire

// [hps_pkg.sv]
// shared constants and types for both ends of the host port link
package hps_pkg;
    localparam int HPS_DW = 16;
    localparam int HPS_WW = 24;
    localparam int HPS_AW = 24;
    localparam int HPS_CW = 4;
    // device port registers, reached on the i/o select
    localparam logic [15:0] HPS_REG_CFG = 16'hFFF0;
    localparam logic [15:0] HPS_REG_PAGE = 16'hFFF1;
    localparam int HPS_CFG_WIDE = 0;
    localparam int HPS_CFG_ACC = 1;
    localparam int HPS_CFG_BEAT = 2;
    localparam int HPS_CFG_POL = 5;
    localparam int HPS_CFG_READY = 6;
    localparam int HPS_CFG_M7 = 7;
    localparam logic [15:0] HPS_CFG_WMASK = 16'h00CD;
    localparam logic [7:0] HPS_PAGE_RST = 8'h00;
    localparam logic [7:0] HPS_PAGE_INT = 8'h00;
    localparam logic [7:0] HPS_PAGE_BOOT = 8'hFF;
    localparam logic [3:0] HPS_DMA_PRIO = 4'hA;
    // strobe time before the host trusts the acknowledge line
    localparam int HPS_CLK_NS = 100;
    localparam int HPS_STB_MIN_NS = 300;
    localparam int HPS_STB_MIN_CYC = (HPS_STB_MIN_NS + HPS_CLK_NS - 1) / HPS_CLK_NS;
    // host command port registers
    localparam logic [3:0] HPS_H_CTRL = 4'h0;
    localparam logic [3:0] HPS_H_ADDR = 4'h1;
    localparam logic [3:0] HPS_H_DATA = 4'h2;
    localparam logic [3:0] HPS_H_STAT = 4'h3;
    localparam logic [3:0] HPS_H_MODE = 4'h4;
    localparam int HPS_HC_WRITE = 0;
    localparam int HPS_HC_IO = 1;
    localparam int HPS_HC_NOADDR = 2;
    localparam int HPS_HC_ACC = 3;
    localparam int HPS_HM_READY = 0;
    localparam int HPS_HM_HIGH = 1;
    typedef enum logic [0:0] {
        HPS_D_IDLE = 1'b0,
        HPS_D_BUSY = 1'b1
    } hps_dma_e;
    typedef enum logic [1:0] {
        HPS_S_IDLE = 2'b00,
        HPS_S_ADDR = 2'b01,
        HPS_S_STB = 2'b10,
        HPS_S_REL = 2'b11
    } hps_hst_e;
endpackage

// [hps_link_if.sv]
// link between external host and host port slave
`timescale 1ns/10ps
`default_nettype none
interface hps_link_if;
    logic [15:0] hst_ad;
    logic hst_ad_oe_n;
    logic [15:0] dev_ad;
    logic dev_ad_oe_n;
    logic host_address_latch_input;
    logic host_write_strobe_n;
    logic host_read_strobe_n;
    logic host_memory_select_n;
    logic host_io_space_select_n;
    logic acknowledge_polarity_strap;
    logic dev_ack;
    logic dev_ack_oe_n;
    logic hst_ack;
    logic hst_ack_oe_n;
    wire logic [15:0] ad;
    wire logic host_acknowledge;
    // wire levels from the enables, undriven reads low
    assign ad = !dev_ad_oe_n ? dev_ad : (!hst_ad_oe_n ? hst_ad : 16'h0000);
    assign host_acknowledge = !dev_ack_oe_n ? dev_ack : (!hst_ack_oe_n ? hst_ack : 1'b0);
    modport dev (
        input ad, host_address_latch_input, host_write_strobe_n, host_read_strobe_n,
        input host_memory_select_n, host_io_space_select_n, acknowledge_polarity_strap,
        input host_acknowledge,
        output dev_ad, dev_ad_oe_n, dev_ack, dev_ack_oe_n
    );
    modport hst (
        input ad, host_acknowledge,
        output hst_ad, hst_ad_oe_n, host_address_latch_input, host_write_strobe_n,
        output host_read_strobe_n, host_memory_select_n, host_io_space_select_n,
        output acknowledge_polarity_strap, hst_ack, hst_ack_oe_n
    );
endinterface
`default_nettype wire

// [hps_hst_end.sv]
// external host end: drives address, strobes and selects for the slave port
`timescale 1ns/10ps
`default_nettype none
module hps_hst_end (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic STRAP_POL,
    input wire logic STRAP_ACK,
    input wire logic [hps_pkg::HPS_CW-1:0] ADDR,
    input wire logic [hps_pkg::HPS_DW-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [hps_pkg::HPS_DW-1:0] RDATA,
    hps_link_if.hst LINK
);
    import hps_pkg::*;

    hps_hst_e st_r, st_nxt;
    logic [3:0] ctrl_r, ctrl_nxt;
    logic [15:0] haddr_r, haddr_nxt;
    logic [15:0] hdata_r, hdata_nxt;
    logic [1:0] mode_r, mode_nxt;
    logic aph_r, aph_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [15:0] rdo_r, rdo_nxt;
    logic act;
    logic [15:0] ad_r, ad_nxt;
    logic ad_oe_n_r, ad_oe_n_nxt;
    logic ale_r, ale_nxt;
    logic wr_n_r, wr_n_nxt;
    logic rd_n_r, rd_n_nxt;
    logic ms_n_r, ms_n_nxt;
    logic ios_n_r, ios_n_nxt;

    // acknowledge active level as this host sees it
    assign act = mode_r[HPS_HM_HIGH] ? LINK.host_acknowledge : !LINK.host_acknowledge;

    // command port and access sequencer
    always_comb begin
        st_nxt = st_r;
        ctrl_nxt = ctrl_r;
        haddr_nxt = haddr_r;
        hdata_nxt = hdata_r;
        mode_nxt = mode_r;
        aph_nxt = aph_r;
        cnt_nxt = (cnt_r == 4'h0) ? cnt_r : 4'(cnt_r - 4'h1);
        rdo_nxt = rdo_r;
        if (RD) begin
            unique case (ADDR)
                HPS_H_CTRL: rdo_nxt = {12'h000, ctrl_r};
                HPS_H_ADDR: rdo_nxt = haddr_r;
                HPS_H_DATA: rdo_nxt = hdata_r;
                HPS_H_STAT: rdo_nxt = {13'h0000, mode_r, st_r != HPS_S_IDLE};
                HPS_H_MODE: rdo_nxt = {14'h0000, mode_r};
                default: rdo_nxt = 16'h0000;
            endcase
        end
        if (WR) begin
            if (ADDR == HPS_H_ADDR) haddr_nxt = WDATA;
            if (ADDR == HPS_H_DATA) hdata_nxt = WDATA;
            if (ADDR == HPS_H_MODE) mode_nxt = WDATA[1:0];
        end
        unique case (st_r)
            HPS_S_IDLE: begin
                if (WR && ADDR == HPS_H_CTRL) begin // chip select per target space [R17]
                    ctrl_nxt = WDATA[3:0];
                    cnt_nxt = 4'(HPS_STB_MIN_CYC);
                    aph_nxt = !WDATA[HPS_HC_NOADDR] && WDATA[HPS_HC_ACC];
                    st_nxt = WDATA[HPS_HC_NOADDR] ? HPS_S_STB
                        : (WDATA[HPS_HC_ACC] ? HPS_S_STB : HPS_S_ADDR);
                end
            end
            HPS_S_ADDR: begin
                if (cnt_r == 4'h0) begin
                    cnt_nxt = 4'(HPS_STB_MIN_CYC);
                    st_nxt = HPS_S_STB;
                end
            end
            HPS_S_STB: begin
                // hold the strobe until acknowledge or ready is seen [R13] [R15]
                if (cnt_r == 4'h0 && act) begin
                    if (!aph_r && !ctrl_r[HPS_HC_WRITE]) hdata_nxt = LINK.ad;
                    st_nxt = HPS_S_REL;
                end
            end
            HPS_S_REL: begin
                // in ack mode wait for the port to drop acknowledge [R13]
                if (mode_r[HPS_HM_READY] || !act) begin
                    cnt_nxt = 4'(HPS_STB_MIN_CYC);
                    aph_nxt = 1'b0;
                    st_nxt = aph_r ? HPS_S_STB : HPS_S_IDLE;
                end
            end
        endcase
        if (!RST_N) begin
            mode_nxt = {STRAP_POL, STRAP_POL == STRAP_ACK};
        end
    end

    // pin levels from the next state
    always_comb begin
        ms_n_nxt = !(st_nxt != HPS_S_IDLE && !ctrl_nxt[HPS_HC_IO]);
        ios_n_nxt = !(st_nxt != HPS_S_IDLE && ctrl_nxt[HPS_HC_IO]);
        ale_nxt = (st_nxt == HPS_S_ADDR) || (st_nxt == HPS_S_STB && aph_nxt);
        wr_n_nxt = !(st_nxt == HPS_S_STB && (aph_nxt || ctrl_nxt[HPS_HC_WRITE]));
        rd_n_nxt = !(st_nxt == HPS_S_STB && !aph_nxt && !ctrl_nxt[HPS_HC_WRITE]);
        ad_nxt = (st_nxt == HPS_S_ADDR || aph_nxt) ? haddr_nxt : hdata_nxt;
        // off on release too: the port may still drive read data then
        ad_oe_n_nxt = !((st_nxt == HPS_S_ADDR || st_nxt == HPS_S_STB) && rd_n_nxt);
    end

    // registers; the strap levels are driven while reset is held
    always_ff @(posedge REF_CLK) begin
        LINK.acknowledge_polarity_strap <= STRAP_POL;
        LINK.hst_ack <= STRAP_ACK;
        LINK.hst_ack_oe_n <= RST_N;
        mode_r <= mode_nxt;
        if (!RST_N) begin
            st_r <= HPS_S_IDLE;
            ctrl_r <= 4'h0;
            haddr_r <= 16'h0000;
            hdata_r <= 16'h0000;
            aph_r <= 1'b0;
            cnt_r <= 4'h0;
            rdo_r <= 16'h0000;
            ad_r <= 16'h0000;
            ad_oe_n_r <= 1'b1;
            ale_r <= 1'b0;
            wr_n_r <= 1'b1;
            rd_n_r <= 1'b1;
            ms_n_r <= 1'b1;
            ios_n_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            ctrl_r <= ctrl_nxt;
            haddr_r <= haddr_nxt;
            hdata_r <= hdata_nxt;
            aph_r <= aph_nxt;
            cnt_r <= cnt_nxt;
            rdo_r <= rdo_nxt;
            ad_r <= ad_nxt;
            ad_oe_n_r <= ad_oe_n_nxt;
            ale_r <= ale_nxt;
            wr_n_r <= wr_n_nxt;
            rd_n_r <= rd_n_nxt;
            ms_n_r <= ms_n_nxt;
            ios_n_r <= ios_n_nxt;
        end
    end

    // multiplexed bus and strobes out [R02]
    assign LINK.hst_ad = ad_r;
    assign LINK.hst_ad_oe_n = ad_oe_n_r;
    assign LINK.host_address_latch_input = ale_r;
    assign LINK.host_write_strobe_n = wr_n_r;
    assign LINK.host_read_strobe_n = rd_n_r;
    assign LINK.host_memory_select_n = ms_n_r;
    assign LINK.host_io_space_select_n = ios_n_r;
    assign RDATA = rdo_r;
endmodule
`default_nettype wire

// [hps_link_monitor.sv]
// checker for the handshake on the host port link
`timescale 1ns/10ps
`default_nettype none
module hps_link_monitor (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic hst_ad_oe_n,
    input wire logic dev_ad_oe_n,
    input wire logic host_address_latch_input,
    input wire logic host_write_strobe_n,
    input wire logic host_read_strobe_n,
    input wire logic host_memory_select_n,
    input wire logic host_io_space_select_n,
    input wire logic acknowledge_polarity_strap,
    input wire logic dev_ack,
    input wire logic dev_ack_oe_n,
    input wire logic hst_ack_oe_n,
    input wire logic host_acknowledge
);
    logic pol_r, pol_nxt, lvl_r, lvl_nxt, stb, sel, on, rdy;
    // strap levels seen on the last reset cycle
    always_comb begin
        pol_nxt = pol_r;
        lvl_nxt = lvl_r;
        if (!RST_N && !hst_ack_oe_n) begin
            pol_nxt = acknowledge_polarity_strap;
            lvl_nxt = host_acknowledge;
        end
    end
    always_ff @(posedge REF_CLK) begin
        pol_r <= pol_nxt;
        lvl_r <= lvl_nxt;
    end
    // strobe, select, active acknowledge and ready mode
    assign stb = !host_read_strobe_n || !host_write_strobe_n;
    assign sel = !host_memory_select_n || !host_io_space_select_n;
    assign on = !dev_ack_oe_n && (dev_ack == pol_r);
    assign rdy = (pol_r == lvl_r);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    sequence s_addr_lead;
        $fell(host_write_strobe_n) && host_address_latch_input && sel;
    endsequence
    sequence s_ack_seen;
        host_acknowledge == pol_r;
    endsequence
    a_ad_one_driver: assert property (!(!dev_ad_oe_n && !hst_ad_oe_n))
        else $error("both ends drive the bus");
    a_dev_ad_read: assert property (!dev_ad_oe_n |->
        !host_read_strobe_n || !$past(host_read_strobe_n))
        else $error("device drives bus outside a read");
    a_one_select: assert property (!(!host_memory_select_n && !host_io_space_select_n))
        else $error("both selects low");
    a_ack_idle_off: assert property ((!rdy && !dev_ack_oe_n && !stb) [*3] |-> !on)
        else $error("ack active without strobe");
    a_ready_idle_on: assert property ((rdy && !dev_ack_oe_n && !stb) [*3] |-> on)
        else $error("ready inactive without strobe");
    a_ack_held: assert property (!rdy && stb && on |=> !stb || on)
        else $error("ack dropped under strobe");
    a_ack_needs_stb: assert property (!rdy && on |-> $past(stb) || $past(stb, 2))
        else $error("ack without a strobe");
    a_addr_cycle_ack: assert property (s_addr_lead |-> ##[2:3] s_ack_seen)
        else $error("address cycle not acknowledged");
    a_strap_release: assert property ($rose(RST_N) |=> hst_ack_oe_n [*4])
        else $error("host keeps driving ack after reset");
endmodule
`default_nettype wire

// [tb_host_port_slave_interface.sv]
// self-checking bench for both ends of the host port link
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module tb_host_port_slave_interface;
    import hps_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic strap_pol = 1'b1;
    logic strap_ack = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic dma_done = 1'b0;
    logic [23:0] dma_rdata = 24'h12_5A5A;
    logic [15:0] rdata, d;
    logic dma_req, dma_wr, wr_l, steal, s_int, s_ext, s_boot, s_io;
    logic [23:0] dma_addr, dma_wdata, addr_l, wdata_l;
    logic [3:0] prio;
    int errors = 0, comparisons = 0, cyc = 0, dma_n = 0, steals = 0, wt = 0, n0, s0;
    logic [7:0] pages [3] = '{8'h05, 8'hFF, 8'h00};
    logic [2:0] sels [3] = '{3'b010, 3'b001, 3'b100};
    hps_link_if link();
    hps_hst_end i_hps_hst_end (.REF_CLK(ref_clk), .RST_N(rst_n), .STRAP_POL(strap_pol),
        .STRAP_ACK(strap_ack), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .LINK(link.hst));
    hps_dev_end i_hps_dev_end (.REF_CLK(ref_clk), .RST_N(rst_n), .LINK(link.dev),
        .DMA_REQ(dma_req), .DMA_WR(dma_wr), .DMA_ADDR(dma_addr), .DMA_WDATA(dma_wdata),
        .DMA_RDATA(dma_rdata), .DMA_DONE(dma_done), .DMA_PRIORITY(prio), .SEL_INT_MEM(s_int),
        .SEL_EXT_MEM(s_ext), .SEL_BOOT(s_boot), .SEL_IO(s_io), .CORE_STEAL(steal));
    hps_link_monitor i_hps_link_monitor (.REF_CLK(ref_clk), .RST_N(rst_n),
        .hst_ad_oe_n(link.hst_ad_oe_n), .dev_ad_oe_n(link.dev_ad_oe_n),
        .host_address_latch_input(link.host_address_latch_input),
        .host_write_strobe_n(link.host_write_strobe_n),
        .host_read_strobe_n(link.host_read_strobe_n),
        .host_memory_select_n(link.host_memory_select_n),
        .host_io_space_select_n(link.host_io_space_select_n),
        .acknowledge_polarity_strap(link.acknowledge_polarity_strap), .dev_ack(link.dev_ack),
        .dev_ack_oe_n(link.dev_ack_oe_n), .hst_ack_oe_n(link.hst_ack_oe_n),
        .host_acknowledge(link.host_acknowledge));
    always #50 ref_clk = ~ref_clk;
    // dma bus: done three cycles into a request, word logged, steals counted
    always @(posedge ref_clk) begin
        dma_done <= dma_req && !dma_done && wt == 2;
        if (dma_req && !dma_done) wt <= (wt == 2) ? 0 : wt + 1;
        if (dma_req && !dma_done && wt == 2) begin
            dma_n <= dma_n + 1;
            wr_l <= dma_wr;
            addr_l <= dma_addr;
            wdata_l <= dma_wdata;
        end
        if (steal) steals <= steals + 1;
        cyc++;
        if (cyc == 30000) begin
            errors++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        if (errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic reset_dut(input logic p, input logic k);
        strap_pol <= p;
        strap_ack <= k;
        rst_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
    endtask
    // command port cycles, one cycle strobes with a gap after
    task automatic cmd_wr(input logic [3:0] a, input logic [15:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic cmd_rd(input logic [3:0] a, output logic [15:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        @(posedge ref_clk);
        v = rdata;
    endtask
    // one link access, busy polled under a bound, result left in d
    task automatic acc(input logic [15:0] c, input logic [15:0] a, input logic [15:0] v);
        logic [15:0] s;
        int n;
        s = 16'h0001;
        n = 0;
        cmd_wr(HPS_H_ADDR, a);
        cmd_wr(HPS_H_DATA, v);
        cmd_wr(HPS_H_CTRL, c);
        while (s[0] !== 1'b0 && n < 300) begin
            cmd_rd(HPS_H_STAT, s);
            n++;
        end
        `CHK("busy", 1'b0, s[0])
        cmd_rd(HPS_H_DATA, d);
    endtask
    initial begin
        reset_dut(1'b1, 1'b0);
        cmd_rd(HPS_H_MODE, d);
        `CHK("mode", 16'h0002, d)
        acc(16'h0002, HPS_REG_CFG, 16'h0000);
        `CHK("cfg reset", 8'h20, d[7:0])
        `CHK("io select", 1'b1, s_io)
        acc(16'h0003, HPS_REG_CFG, 16'h0081);
        acc(16'h0002, HPS_REG_CFG, 16'h0000);
        `CHK("cfg written", 16'h00A1, d)
        s0 = steals;
        acc(16'h0001, 16'h1234, 16'hBEEF);
        `CHK("dma write", 1'b1, wr_l)
        `CHK("dma wdata", 16'hBEEF, wdata_l[15:0])
        `CHK("core steal", s0 + 1, steals)
        `CHK("priority", 4'hA, prio)
        acc(16'h0000, 16'h2000, 16'h0000);
        `CHK("read data", 16'h5A5A, d)
        `CHK("read addr", 24'h00_2000, addr_l)
        acc(16'h0004, 16'h0000, 16'h0000);
        `CHK("auto inc", 24'h00_2001, addr_l)
        for (int i = 0; i < 3; i++) begin
            acc(16'h000B, HPS_REG_PAGE, {8'h00, pages[i]});
            s0 = steals;
            acc(16'h0009, 16'h0010, 16'h1111);
            `CHK("selects", sels[i], {s_int, s_ext, s_boot})
            `CHK("page addr", {pages[i], 16'h0010}, addr_l)
            `CHK("steal", s0 + (i == 2), steals)
        end
        acc(16'h000B, HPS_REG_CFG, 16'h0088);
        n0 = dma_n;
        acc(16'h0009, 16'h3000, 16'h0011);
        `CHK("no early dma", n0, dma_n)
        acc(16'h000D, 16'h0000, 16'h0022);
        acc(16'h000D, 16'h0000, 16'h0033);
        `CHK("one dma", n0 + 1, dma_n)
        `CHK("word", 24'h33_2211, wdata_l)
        reset_dut(1'b0, 1'b0);
        cmd_rd(HPS_H_MODE, d);
        `CHK("mode ready", 16'h0001, d)
        acc(16'h0002, HPS_REG_CFG, 16'h0000);
        `CHK("cfg ready", 8'h40, d[7:0])
        acc(16'h0000, 16'h0042, 16'h0000);
        `CHK("read ready", 8'h5A, d[7:0])
        give_verdict();
    end
endmodule
`default_nettype wire
